// File: dv/lead_off_ac_chk.sv
// checker: port-level assertions for the ac lead-off control block
`timescale 1ns/1ns
module lead_off_ac_chk
  import lod_ac_pkg::*;
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             arst_n,
  // bus select
  input  wire logic             hsel,
  // analog front controls
  input  wire excite_t          excite,
  input  wire logic [CUR_W-1:0] test_current_code,
  input  wire logic             lead_off_detect_on,
  input  wire logic             dc_mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // ==========
  // switch drive
  // source and sink on one pin together would short the test current
  pin_compl_a: assert property ((excite.src & excite.snk) == '0)
    else $error("pin source and sink on together");
  chan_bal_a: assert property ((excite.ch_pos & excite.ch_neg) == '0)
    else $error("channel current both signs at once");
  off_quiet_a: assert property (!lead_off_detect_on |->
    excite == '0 && test_current_code == '0 && !dc_mode)
    else $error("drive active while shut down");
  dc_no_ac_a: assert property (dc_mode |->
    excite.snk == '0 && excite.ch_pos == '0 && excite.ch_neg == '0)
    else $error("ac drive in dc mode");
  ana_only_a: assert property (|excite.snk |->
    excite.ch_pos == '0 && excite.ch_neg == '0)
    else $error("pin and channel drive mixed");
  chan_mode_a: assert property (|{excite.ch_pos, excite.ch_neg} |->
    lead_off_detect_on && !dc_mode)
    else $error("channel drive outside digital ac");
  // after a restart the tone begins on the source half
  tone_alt_a: assert property ($rose(excite.snk[0]) |-> $past(excite.src[0]))
    else $error("sink half not preceded by source half");
  // only a bus access may move the dc switches
  dc_steady_a: assert property (
    dc_mode && $past(dc_mode) && !$past(hsel) && !$past(hsel, 2) && !$past(hsel, 3)
    |-> $stable(excite.src))
    else $error("dc switches moved without access");
endmodule // lead_off_ac_chk

bind lead_off_ac_ctrl lead_off_ac_chk chk_u (
  .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .excite(excite),
  .test_current_code(test_current_code), .lead_off_detect_on(lead_off_detect_on),
  .dc_mode(dc_mode));

// File: dv/lead_off_ac_ctrl_tb.sv
// testbench: bus-driven scenarios for the ac lead-off control block
`timescale 1ns/1ns
module lead_off_ac_ctrl_tb
  import lod_ac_pkg::*;
;
  logic                 mclk, arst_n, hsel, hwrite, hreadyout, hresp, irq;
  logic                 lead_off_detect_on, dc_mode;
  logic [7:0]           haddr, test_current_code;
  logic [1:0]           htrans, comparator_threshold_level;
  logic [2:0]           hsize;
  logic [31:0]          hwdata, hrdata, r;
  logic [5:0]           comp_in;
  excite_t              excite;
  int                   mismatches, compares, c, e;
  logic [7:0]           ofs [7] = '{OFS_CONTROL, OFS_FREQ, OFS_ENABLE, OFS_CURRENT,
                                    OFS_FLAGS, OFS_IRQ_STAT, OFS_IRQ_MASK};
  logic [7:0]           ctl [5] = '{8'h01, 8'h00, 8'h02, 8'h06, 8'h07};
  lod_mode_t            md [5]  = '{MODE_OFF, MODE_DC, MODE_DIG_AC, MODE_ANA_AC, MODE_OFF};
  logic [7:0]           fq [3]  = '{8'h01, 8'h00, 8'h80};

  lead_off_ac_ctrl dut_u (
    .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comp_in(comp_in),
    .excite(excite), .test_current_code(test_current_code),
    .comparator_threshold_level(comparator_threshold_level),
    .lead_off_detect_on(lead_off_detect_on), .dc_mode(dc_mode), .irq(irq));

  // ==========
  // clock and tasks
  always #50 mclk = ~mclk;

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    compares++;
    if (g !== ex) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // bounded wait so a stuck slave ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 64) begin
        mismatches++;
        print_verdict();
      end
      @(posedge mclk);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
    xfer(1'b0, a, 32'h0);
    chk(nm, ex, r);
  endtask

  // length of the next sink half of pin zero, in clocks
  task automatic half(output int n);
    int w;
    w = 0;
    n = 0;
    while (excite.snk[0] !== 1'b1 && w < 20000) begin
      @(posedge mclk);
      w++;
    end
    while (excite.snk[0] === 1'b1 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
  endtask

  // ==========
  // main sequence
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    {hsel, hwrite, haddr, htrans, hwdata, comp_in} = '0;
    hsize = 3'b010;
    mismatches = 0;
    compares = 0;
    tick(20);
    arst_n <= 1'b1;
    foreach (ofs[i]) rd("reset value", ofs[i], 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rd("unmapped", 8'h20, 32'h0);
    chk("bus response", 32'h0, 32'(hresp));
    rd("mode", OFS_MODE, 32'(MODE_DC));
    wr(OFS_CURRENT, 32'hFF);
    rd("current", OFS_CURRENT, 32'hFF);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CONTROL, 32'(ctl[i]));
      tick(2);
      rd("mode", OFS_MODE, 32'(md[i]));
      chk("detect on", 32'(!ctl[i][0]), 32'(lead_off_detect_on));
      chk("dc mode", 32'(ctl[i][2:0] == 3'b000), 32'(dc_mode));
      chk("current", ctl[i][0] ? 32'h0 : 32'hFF, 32'(test_current_code));
    end
    // enable while shut down, so every tone starts on its source half
    wr(OFS_ENABLE, 32'h01);
    for (int l = 0; l < 4; l++) begin
      wr(OFS_CONTROL, 32'(l * 8 + 6));
      tick(2);
      chk("level", 32'(l), 32'(comparator_threshold_level));
    end
    foreach (fq[i]) begin
      wr(OFS_FREQ, 32'(fq[i]));
      tick(3);
      chk("source", 32'h1, 32'(excite.src));
      chk("sink", 32'h0, 32'(excite.snk));
      half(c);
      e = BASE_DIV * 2 * (fq[i][7] ? 16 : 1) * (int'(fq[i][6:0]) + 1);
      chk("half period", 32'(e), 32'(c));
    end
    wr(OFS_FREQ, 32'h00);
    wr(OFS_ENABLE, 32'h16);
    wr(OFS_CONTROL, 32'h02);
    tick(200);
    chk("chan pos", 32'h4, 32'(excite.ch_pos));
    chk("chan neg", 32'h2, 32'(excite.ch_neg));
    tick(400);
    chk("chan pos", 32'h2, 32'(excite.ch_pos));
    chk("chan neg", 32'h4, 32'(excite.ch_neg));
    wr(OFS_ENABLE, 32'h08);
    wr(OFS_CONTROL, 32'h06);
    comp_in <= 6'h18;
    tick(8);
    rd("flags", OFS_FLAGS, 32'h08);
    rd("status", OFS_IRQ_STAT, 32'h08);
    chk("irq masked", 32'h0, 32'(irq));
    wr(OFS_IRQ_MASK, 32'h08);
    tick(2);
    chk("irq", 32'h1, 32'(irq));
    wr(OFS_IRQ_STAT, 32'h08);
    tick(2);
    chk("irq cleared", 32'h0, 32'(irq));
    rd("status", OFS_IRQ_STAT, 32'h0);
    wr(OFS_CONTROL, 32'h07);
    tick(8);
    rd("flags off", OFS_FLAGS, 32'h0);
    print_verdict();
  end
endmodule // lead_off_ac_ctrl_tb

// File: include/lod_ac_pkg.sv
// package: register map, field layouts and timing counts of the ac lead-off control block
package lod_ac_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_FREQ      = 8'h04;
  localparam logic [7:0] OFS_ENABLE    = 8'h08;
  localparam logic [7:0] OFS_CURRENT   = 8'h0C;
  localparam logic [7:0] OFS_FLAGS     = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h18;
  localparam logic [7:0] OFS_MODE      = 8'h1C;

  // control register field positions
  localparam int CTL_SHUTDOWN_BIT = 0;
  localparam int CTL_AC_SEL_BIT   = 1;
  localparam int CTL_ANALOG_BIT   = 2;
  localparam int CTL_LEVEL_LSB    = 3;
  localparam int LEVEL_W          = 2;

  // frequency control field positions
  localparam int FREQ_DIV_W       = 7;
  localparam int FREQ_X16_BIT     = 7;

  localparam int PIN_COUNT        = 6;
  localparam int CHAN_COUNT       = 3;
  localparam int CUR_W            = 8;
  localparam int STAT_W           = PIN_COUNT;

  // reset values
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] FREQ_RST     = 8'h00;
  localparam logic [5:0] ENABLE_RST   = 6'h00;
  localparam logic [7:0] CURRENT_RST  = 8'h00;
  localparam logic [5:0] MASK_RST     = 6'h00;

  // timing: base tone clock of 50 kHz from a 10 MHz clock
  localparam int MCLK_HZ          = 10_000_000;
  localparam int BASE_HZ          = 50_000;
  localparam int BASE_DIV         = MCLK_HZ / BASE_HZ;
  localparam logic [7:0] BASE_DIV_M1 = 8'(BASE_DIV - 1);
  localparam logic [10:0] X16_COUNT  = 11'h010;

  // current step in nanoamps per code
  localparam int CUR_STEP_NA      = 8;

  // lead-off operating mode, gray coded
  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_DC     = 2'b01,
    MODE_DIG_AC = 2'b11,
    MODE_ANA_AC = 2'b10
  } lod_mode_t;

  // configuration carried to the excitation divider
  typedef struct packed {
    logic                  run;
    logic                  x16;
    logic [FREQ_DIV_W-1:0] div;
  } div_cfg_t;

  // switch drive to the analog front
  typedef struct packed {
    logic [PIN_COUNT-1:0]  src;
    logic [PIN_COUNT-1:0]  snk;
    logic [CHAN_COUNT-1:0] ch_pos;
    logic [CHAN_COUNT-1:0] ch_neg;
  } excite_t;

endpackage

// File: rtl/excite_divider.sv
// excitation tone divider: 50 kHz base, then divide by 4*K*(N+1)
`timescale 1ns/1ns
module excite_divider
  import lod_ac_pkg::*;
(
  // clock and reset
  input  wire logic     mclk,
  input  wire logic     arst_n,
  // configuration
  input  wire div_cfg_t cfg,
  // tone phase, high half then low half
  output logic          phase
);

  logic [7:0]  base_q, base_d;
  logic [12:0] cnt_q, cnt_d;
  logic        phase_q, phase_d;
  div_cfg_t    cfg_q, cfg_d;
  logic [12:0] half_len;

  // half period in base ticks is 2*K*(N+1); x16 reaches 4096, hence 13 bits
  always_comb begin
    half_len = {5'h00, cfg.div, 1'b0} + 13'h0002;
    if (cfg.x16) begin
      half_len = {2'h0, cfg.div, 4'h0} + {2'h0, X16_COUNT};
      half_len = {half_len[11:0], 1'b0};
    end
  end

  // restart on the high half on any settings change or stop
  always_comb begin
    cfg_d   = cfg;
    base_d  = base_q;
    cnt_d   = cnt_q;
    phase_d = phase_q;
    if (!cfg.run || cfg != cfg_q) begin
      base_d  = 8'h00;
      cnt_d   = 13'h0000;
      phase_d = 1'b1;
    end else if (base_q == BASE_DIV_M1) begin
      base_d = 8'h00;
      if (cnt_q == half_len - 13'h0001) begin
        cnt_d   = 13'h0000;
        phase_d = !phase_q;
      end else begin
        cnt_d = cnt_q + 13'h0001;
      end
    end else begin
      base_d = base_q + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      base_q  <= 8'h00;
      cnt_q   <= 13'h0000;
      phase_q <= 1'b1;
      cfg_q   <= '0;
    end else begin
      base_q  <= base_d;
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
      cfg_q   <= cfg_d;
    end
  end

  assign phase = phase_q;

endmodule // excite_divider

// File: rtl/lead_off_ac_ctrl.sv
// lead-off excitation control with ahb-lite register slave and interrupt
`timescale 1ns/1ns

// Contract
// - analog ac when ac and analog bits set
// - tone is 50 kHz over 4*K*(N+1)
// - analog mode drives complementary pin switches
// - two-bit field selects comparator threshold
// - enabled pin comparator result sets flag; digital ac keeps pin flags at zero
// - digital ac when ac set, analog clear
// - low enables select channels one to three
// - high enables invert channel excitation phase
// - digital mode drives balanced opposite currents
// - digital current magnitude from current code
// - ac bit clear means dc mode
// - shutdown stops excitation and flags
// - eight-bit current code, 8 nA steps
module lead_off_ac_ctrl
  import lod_ac_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // comparator outputs from the pins, asynchronous
  input  wire logic [PIN_COUNT-1:0]  comp_in,
  // analog front controls
  output excite_t                    excite,
  output logic [CUR_W-1:0]           test_current_code,
  output logic [LEVEL_W-1:0]         comparator_threshold_level,
  output logic                       lead_off_detect_on,
  output logic                       dc_mode,
  // interrupt
  output logic                       irq
);

  // ==========================================================
  // registers
  // ==========================================================
  // software view, one word per register at byte offsets:
  //   control  : shutdown, ac select, analog select, two-bit threshold level
  //   frequency: seven-bit divider value and the divide-by-sixteen bit
  //   enable   : six pin enables; in digital ac the low three pick channels
  //              and the high three invert their phase
  //   current  : eight-bit test current code
  //   flags    : per-pin lead-off result, read only
  //   status   : sticky flag rises, write one to clear
  //   mask     : interrupt mask, same layout as status
  //   mode     : decoded operating mode, read only
  // unused bits read zero and ignore writes, so later fields stay compatible
  logic [7:0]           ctl_q, ctl_d;
  logic [7:0]           freq_q, freq_d;
  logic [PIN_COUNT-1:0] en_q, en_d;
  logic [CUR_W-1:0]     cur_q, cur_d;
  logic [STAT_W-1:0]    stat_q, stat_d;
  logic [STAT_W-1:0]    mask_q, mask_d;
  logic [PIN_COUNT-1:0] flag_q, flag_d;
  logic                 wr_pend_q, wr_pend_d;
  logic [7:0]           wr_addr_q, wr_addr_d;
  logic [31:0]          rdata_q, rdata_d;

  // ==========================================================
  // mode decode
  // ==========================================================
  lod_mode_t mode;
  logic      shutdown;
  logic      ac_sel;
  logic      analog_not_digital_select;

  assign shutdown                  = ctl_q[CTL_SHUTDOWN_BIT];
  assign ac_sel                    = ctl_q[CTL_AC_SEL_BIT];
  assign analog_not_digital_select = ctl_q[CTL_ANALOG_BIT];

  // mode codes step by one bit along off, dc, digital ac, analog ac, so a
  // reader of the mode word never sees a two-bit jump on the usual path
  // shutdown overrides every mode
  always_comb begin
    if (shutdown) begin
      mode = MODE_OFF;
    end else if (!ac_sel) begin
      mode = MODE_DC;
    end else if (analog_not_digital_select) begin
      mode = MODE_ANA_AC;
    end else begin
      mode = MODE_DIG_AC;
    end
  end

  // ==========================================================
  // excitation divider
  // ==========================================================
  div_cfg_t  dcfg;
  logic      phase;
  lod_mode_t mode_q;
  logic      mode_chg;
  logic      ph_eff;

  // same divider fields serve both ac modes; run drops for the one cycle in
  // which the mode moves, so a jump between the two ac modes also restarts
  // the tone from its first half
  assign mode_chg = (mode != mode_q);
  assign dcfg.run = ((mode == MODE_ANA_AC) || (mode == MODE_DIG_AC))
                    && !mode_chg;
  assign dcfg.x16 = freq_q[FREQ_X16_BIT];
  assign dcfg.div = freq_q[FREQ_DIV_W-1:0];

  excite_divider u_div (
    .mclk   (mclk),
    .arst_n (arst_n),
    .cfg    (dcfg),
    .phase  (phase)
  );

  // the divider shows its restart phase one cycle after a mode move; force
  // the first half here so a fresh tone never opens on the sink half
  assign ph_eff = phase || mode_chg;

  // ==========================================================
  // switch drive
  // ==========================================================
  excite_t               exc_q, exc_d;
  logic [CHAN_COUNT-1:0] dig_ph;
  logic [CHAN_COUNT-1:0] dig_pos;
  logic [CHAN_COUNT-1:0] dig_neg;

  // per channel: a set upper enable bit runs that channel in anti-phase,
  // so two channels sharing one electrode can be made to add, not cancel
  genvar gc;
  generate
    for (gc = 0; gc < CHAN_COUNT; gc++) begin : g_chan
      assign dig_ph[gc]  = ph_eff ^ en_q[CHAN_COUNT + gc];
      assign dig_pos[gc] = en_q[gc] & dig_ph[gc];
      assign dig_neg[gc] = en_q[gc] & !dig_ph[gc];
    end
  endgenerate

  // only one switch set is live at a time; the others stay open
  always_comb begin
    exc_d = '0;
    case (mode)
      MODE_ANA_AC: begin
        // complementary source and sink per enabled pin
        exc_d.src = en_q & {PIN_COUNT{ph_eff}};
        exc_d.snk = en_q & {PIN_COUNT{!ph_eff}};
      end
      MODE_DIG_AC: begin
        // balanced currents at each channel's positive and negative input
        exc_d.ch_pos = dig_pos;
        exc_d.ch_neg = dig_neg;
      end
      MODE_DC: begin
        exc_d.src = en_q;                              // steady current copy
      end
      default: begin
        exc_d = '0;
      end
    endcase
  end

  // ==========================================================
  // comparator synchroniser and flags
  // ==========================================================
  logic [PIN_COUNT-1:0] s1_q, s2_q, s3_q;
  logic [PIN_COUNT-1:0] comp_ok;

  // three stages; result only changes when stages two and three agree
  // the first stage may go metastable, so only stages two and three are read
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= comp_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < PIN_COUNT; gp++) begin : g_pin
      // hold previous flag while stages disagree
      assign comp_ok[gp] = (s2_q[gp] == s3_q[gp]) ? s3_q[gp] : flag_q[gp];
    end
  endgenerate

  // digital ac judges leads from converted data, so pin flags rest at zero
  always_comb begin
    flag_d = '0;
    if (mode != MODE_OFF && mode != MODE_DIG_AC) begin
      flag_d = comp_ok & en_q;
    end
  end

  // ==========================================================
  // ahb-lite slave, zero wait state
  // ==========================================================
  logic       take;
  logic [7:0] word_addr;
  logic       wr_hit;

  assign take   = hsel && hready && htrans[1];
  assign wr_hit = wr_pend_q;

  // the address phase is taken where select, ready and a nonsequential or sequential transfer
  // meet; writes land at the end of the data phase and reads come from a
  // register, so the slave never needs a wait state
  always_comb begin
    wr_pend_d = take && hwrite;
    wr_addr_d = take ? {haddr[7:2], 2'b00} : wr_addr_q;
    word_addr = {haddr[7:2], 2'b00};
    rdata_d   = 32'h0000_0000;
    if (take && !hwrite) begin
      if (word_addr == OFS_CONTROL) begin
        rdata_d = {24'h0, ctl_q};
      end else if (word_addr == OFS_FREQ) begin
        rdata_d = {24'h0, freq_q};
      end else if (word_addr == OFS_ENABLE) begin
        rdata_d = {26'h0, en_q};
      end else if (word_addr == OFS_CURRENT) begin
        rdata_d = {24'h0, cur_q};
      end else if (word_addr == OFS_FLAGS) begin
        rdata_d = {26'h0, flag_q};
      end else if (word_addr == OFS_IRQ_STAT) begin
        rdata_d = {26'h0, stat_q};
      end else if (word_addr == OFS_IRQ_MASK) begin
        rdata_d = {26'h0, mask_q};
      end else if (word_addr == OFS_MODE) begin
        rdata_d = {30'h0, mode};
      end else begin
        rdata_d = 32'h0000_0000;                       // unmapped reads zero
      end
    end
  end

  // register writes in the data phase; flag rises set status
  always_comb begin
    ctl_d  = ctl_q;
    freq_d = freq_q;
    en_d   = en_q;
    cur_d  = cur_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr_hit) begin
      if (wr_addr_q == OFS_CONTROL) begin
        ctl_d = {3'h0, hwdata[4:0]};                   // level in bits 4:3
      end else if (wr_addr_q == OFS_FREQ) begin
        freq_d = hwdata[7:0];
      end else if (wr_addr_q == OFS_ENABLE) begin
        en_d = hwdata[5:0];
      end else if (wr_addr_q == OFS_CURRENT) begin
        cur_d = hwdata[7:0];
      end else if (wr_addr_q == OFS_IRQ_STAT) begin
        stat_d = stat_q & ~hwdata[5:0];
      end else if (wr_addr_q == OFS_IRQ_MASK) begin
        mask_d = hwdata[5:0];
      end
    end
    // a new lead-off event wins over a clear in the same cycle
    stat_d = stat_d | (flag_d & ~flag_q);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_q     <= CONTROL_RST;
      freq_q    <= FREQ_RST;
      en_q      <= ENABLE_RST;
      cur_q     <= CURRENT_RST;
      stat_q    <= '0;
      mask_q    <= MASK_RST;
      flag_q    <= '0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      mode_q    <= MODE_OFF;
      rdata_q   <= 32'h0000_0000;
      exc_q     <= '0;
    end else begin
      ctl_q     <= ctl_d;
      freq_q    <= freq_d;
      en_q      <= en_d;
      cur_q     <= cur_d;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      flag_q    <= flag_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      mode_q    <= mode;
      rdata_q   <= rdata_d;
      exc_q     <= exc_d;
    end
  end

  // ==========================================================
  // registered outputs
  // ==========================================================
  logic                 irq_q;
  logic [LEVEL_W-1:0]   lvl_q;
  logic                 on_q, dc_q;
  logic [CUR_W-1:0]     cur_out_q;

  // front-end controls are registered from the decoded mode, so they move on the
  // same edge as the switches and never disagree with them for a cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q     <= 1'b0;
      lvl_q     <= '0;
      on_q      <= 1'b0;
      dc_q      <= 1'b0;
      cur_out_q <= '0;
    end else begin
      irq_q     <= |(stat_d & mask_d);
      lvl_q     <= ctl_q[CTL_LEVEL_LSB +: LEVEL_W];
      on_q      <= (mode != MODE_OFF);
      dc_q      <= (mode == MODE_DC);
      cur_out_q <= shutdown ? '0 : cur_q;
    end
  end

  assign hrdata                     = rdata_q;
  assign hreadyout                  = 1'b1;   // never stalls, no wait states
  assign hresp                      = 1'b0;
  assign excite                     = exc_q;
  assign test_current_code          = cur_out_q;
  assign comparator_threshold_level = lvl_q;
  assign lead_off_detect_on         = on_q;
  assign dc_mode                    = dc_q;
  assign irq                        = irq_q;

endmodule // lead_off_ac_ctrl
